// ---- src/dsg_pkg.sv ----
// deep-sleep clock gating: shared constants, types and the unit map
// assumes one 20 MHz clock and register access over AXI4-Lite
// What this block does
// - with auto select, deep sleep clocks units whose bit is set
// - with auto select, deep sleep stops units whose bit is clear
// - access to unclocked unit gets bus fault
// - gating register resets to all zeros
// - this register applies only in deep sleep
// - auto select uses sleep/deep-sleep registers
// - bit 16 gates the USB unit
// - bit 13 gates the DMA unit
// - bits 7..0 gate ports H down to A
// - other bits read zero, ignore writes
package dsg_pkg;
	localparam int unsigned ADDR_W        = 12;
	localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
	localparam logic [11:0] EFF_GATE_OFS  = 12'h12c;
	localparam logic [31:0] DEEP_GATE_RST = 32'h0000_0000;
	localparam logic [31:0] DEEP_WR_MASK  = 32'h0001_20ff;
	localparam int unsigned USB_BIT       = 16;
	localparam int unsigned DMA_BIT       = 13;
	localparam int unsigned PORT_HI_BIT   = 7;
	localparam int unsigned NUM_UNITS     = 10;
	localparam logic [3:0]  NUM_UNITS_4   = 4'ha;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;

	typedef enum logic [1:0] {
		PM_RUN   = 2'h0,
		PM_SLEEP = 2'h1,
		PM_DEEP  = 2'h2
	} dsg_pmode_t;

	// gray along idle -> addr/data -> resp
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_ADDR = 2'h1,
		WR_RESP = 2'h3,
		WR_DATA = 2'h2
	} dsg_wst_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} dsg_rst_t;

	// unit index: 0..7 ports a..h, 8 dma, 9 usb
	typedef struct packed {
		logic       valid;
		logic [3:0] unit;
	} dsg_access_t;

	typedef logic [NUM_UNITS-1:0] dsg_units_t;

	function automatic dsg_units_t dsg_unit_vec(input logic [31:0] r);
		dsg_unit_vec = {r[USB_BIT], r[DMA_BIT], r[PORT_HI_BIT:0]};
	endfunction

	function automatic logic [31:0] dsg_unit_word(input dsg_units_t u);
		dsg_unit_word = 32'h0;
		dsg_unit_word[USB_BIT] = u[9];
		dsg_unit_word[DMA_BIT] = u[8];
		dsg_unit_word[PORT_HI_BIT:0] = u[7:0];
	endfunction
endpackage

// ---- src/dsg_en_switch.sv ----
// one unit's clock enable, picked from run, sleep or deep-sleep source
// assumes all sources come from logic on aclk
`timescale 1ns/100ps
`default_nettype none
module dsg_en_switch (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// enable sources
	input  wire logic              run_en,
	input  wire logic              sleep_en,
	input  wire logic              deep_en,
	input  wire logic              auto_sel,
	input  wire dsg_pkg::dsg_pmode_t mode,
	// registered enable
	output logic                   clk_en
);
	logic next_clk_en;

	always_comb begin
		next_clk_en = run_en;
		if (auto_sel) begin
			case (mode)
				dsg_pkg::PM_SLEEP: next_clk_en = sleep_en;
				dsg_pkg::PM_DEEP:  next_clk_en = deep_en;
				default:           next_clk_en = run_en;
			endcase
		end
	end

	// source changes land only on a clock edge, so the enable never glitches
	always_ff @(posedge aclk) begin
		if (!aresetn)
			clk_en <= 1'b0;
		else
			clk_en <= next_clk_en;
	end
endmodule // dsg_en_switch
`default_nettype wire

// ---- src/dsg_fault_check.sv ----
// answers a peripheral access with grant or bus fault
// assumes the enables are the ones being delivered to the units
`timescale 1ns/100ps
`default_nettype none
module dsg_fault_check (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// access and present enables
	input  wire dsg_pkg::dsg_access_t access,
	input  wire dsg_pkg::dsg_units_t  units,
	// one-cycle answers
	output logic                      fault,
	output logic                      grant
);
	logic clocked;
	logic next_fault;
	logic next_grant;

	always_comb begin
		clocked = 1'b0;
		// a unit index past the map has no clock at all
		if (access.unit < dsg_pkg::NUM_UNITS_4)
			clocked = units[access.unit];
		next_fault = access.valid && !clocked;
		next_grant = access.valid && clocked;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault <= 1'b0;
			grant <= 1'b0;
		end else begin
			fault <= next_fault;
			grant <= next_grant;
		end
	end
endmodule // dsg_fault_check
`default_nettype wire

// ---- src/dsg_top.sv ----
// deep-sleep gating register, enable selection and access fault check
// assumes an AXI4-Lite master and mode/run/sleep sources on aclk
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dsg_top (
	// clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// write address channel
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [dsg_pkg::ADDR_W-1:0] awaddr,
	// write data channel
	input  wire logic                       wvalid,
	output logic                            wready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	// write response channel
	output logic                            bvalid,
	input  wire logic                       bready,
	output logic [1:0]                      bresp,
	// read address channel
	input  wire logic                       arvalid,
	output logic                            arready,
	input  wire logic [dsg_pkg::ADDR_W-1:0] araddr,
	// read data channel
	output logic                            rvalid,
	input  wire logic                       rready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	// power state and companion enables
	input  wire dsg_pkg::dsg_pmode_t        power_mode,
	input  wire logic                       auto_gate_select,
	input  wire logic [31:0]                run_gate_reg,
	input  wire logic [31:0]                sleep_gate_reg,
	// peripheral access check
	input  wire dsg_pkg::dsg_access_t       unit_access,
	output logic                            access_fault,
	output logic                            access_grant,
	// per-unit clock enables
	output dsg_pkg::dsg_units_t             unit_clk_en
);
	localparam int unsigned AW = dsg_pkg::ADDR_W;

	dsg_pkg::dsg_wst_t  wst;
	dsg_pkg::dsg_wst_t  next_wst;
	dsg_pkg::dsg_rst_t  rd_state;
	dsg_pkg::dsg_rst_t  next_rd_state;
	logic [AW-1:0]      waddr;
	logic [AW-1:0]      next_waddr;
	logic [31:0]        wdata_h;
	logic [31:0]        next_wdata_h;
	logic [3:0]         wstrb_h;
	logic [3:0]         next_wstrb_h;
	logic [31:0]        deep_gate_reg;
	logic [31:0]        next_deep_gate_reg;
	logic               next_awready;
	logic               next_wready;
	logic               next_bvalid;
	logic [1:0]         next_bresp;
	logic               next_arready;
	logic               next_rvalid;
	logic [31:0]        next_rdata;
	logic [1:0]         next_rresp;
	logic               aw_take;
	logic               w_take;
	logic               wr_hit_deep;
	logic               wr_hit_eff;
	logic [31:0]        byte_mask;
	dsg_pkg::dsg_units_t run_units;
	dsg_pkg::dsg_units_t sleep_units;
	dsg_pkg::dsg_units_t deep_units;

	assign run_units   = dsg_pkg::dsg_unit_vec(run_gate_reg);
	assign sleep_units = dsg_pkg::dsg_unit_vec(sleep_gate_reg);
	assign deep_units  = dsg_pkg::dsg_unit_vec(deep_gate_reg);

	// write path: address and data taken in either order, then one response
	always_comb begin
		next_wst           = wst;
		next_waddr         = waddr;
		next_wdata_h       = wdata_h;
		next_wstrb_h       = wstrb_h;
		next_bvalid        = bvalid;
		next_bresp         = bresp;
		next_deep_gate_reg = deep_gate_reg;
		aw_take            = awvalid && awready;
		w_take             = wvalid && wready;
		wr_hit_deep = waddr[AW-1:2] == dsg_pkg::DEEP_GATE_OFS[AW-1:2];
		wr_hit_eff  = waddr[AW-1:2] == dsg_pkg::EFF_GATE_OFS[AW-1:2];
		byte_mask = {{8{wstrb_h[3]}}, {8{wstrb_h[2]}},
			{8{wstrb_h[1]}}, {8{wstrb_h[0]}}};
		if (aw_take)
			next_waddr = awaddr;
		if (w_take) begin
			next_wdata_h = wdata;
			next_wstrb_h = wstrb;
		end
		case (wst)
			dsg_pkg::WR_IDLE: begin
				if (aw_take && w_take)
					next_wst = dsg_pkg::WR_RESP;
				else if (aw_take)
					next_wst = dsg_pkg::WR_ADDR;
				else if (w_take)
					next_wst = dsg_pkg::WR_DATA;
			end
			dsg_pkg::WR_ADDR: begin
				if (w_take)
					next_wst = dsg_pkg::WR_RESP;
			end
			dsg_pkg::WR_DATA: begin
				if (aw_take)
					next_wst = dsg_pkg::WR_RESP;
			end
			dsg_pkg::WR_RESP: begin
				if (!bvalid) begin
					// commit once, on the first response cycle
					if (wr_hit_deep)
						next_deep_gate_reg = ((deep_gate_reg & ~byte_mask)
							| (wdata_h & byte_mask))
							& dsg_pkg::DEEP_WR_MASK;
					next_bvalid = 1'b1;
					next_bresp  = (wr_hit_deep || wr_hit_eff) ?
						dsg_pkg::RESP_OKAY : dsg_pkg::RESP_DECERR;
				end else if (bready) begin
					next_bvalid = 1'b0;
					next_wst    = dsg_pkg::WR_IDLE;
				end
			end
			default: next_wst = dsg_pkg::WR_IDLE;
		endcase
		next_awready = next_wst == dsg_pkg::WR_IDLE
			|| next_wst == dsg_pkg::WR_DATA;
		next_wready  = next_wst == dsg_pkg::WR_IDLE
			|| next_wst == dsg_pkg::WR_ADDR;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst           <= dsg_pkg::WR_IDLE;
			waddr         <= '0;
			wdata_h       <= 32'h0;
			wstrb_h       <= 4'h0;
			awready       <= 1'b0;
			wready        <= 1'b0;
			bvalid        <= 1'b0;
			bresp         <= dsg_pkg::RESP_OKAY;
			deep_gate_reg <= dsg_pkg::DEEP_GATE_RST;
		end else begin
			wst           <= next_wst;
			waddr         <= next_waddr;
			wdata_h       <= next_wdata_h;
			wstrb_h       <= next_wstrb_h;
			awready       <= next_awready;
			wready        <= next_wready;
			bvalid        <= next_bvalid;
			bresp         <= next_bresp;
			deep_gate_reg <= next_deep_gate_reg;
		end
	end

	// read path: one read at a time, answered the cycle after it is taken
	always_comb begin
		next_rd_state = rd_state;
		next_arready  = arready;
		next_rvalid   = rvalid;
		next_rdata    = rdata;
		next_rresp    = rresp;
		case (rd_state)
			dsg_pkg::RD_IDLE: begin
				if (arvalid && arready) begin
					next_rd_state = dsg_pkg::RD_RESP;
					next_arready  = 1'b0;
					next_rvalid   = 1'b1;
					next_rresp    = dsg_pkg::RESP_OKAY;
					if (araddr[AW-1:2] == dsg_pkg::DEEP_GATE_OFS[AW-1:2])
						next_rdata = deep_gate_reg;
					else if (araddr[AW-1:2] == dsg_pkg::EFF_GATE_OFS[AW-1:2])
						next_rdata = dsg_pkg::dsg_unit_word(unit_clk_en);
					else begin
						next_rdata = 32'h0;
						next_rresp = dsg_pkg::RESP_DECERR;
					end
				end else
					next_arready = 1'b1;
			end
			dsg_pkg::RD_RESP: begin
				if (rready) begin
					next_rd_state = dsg_pkg::RD_IDLE;
					next_rvalid   = 1'b0;
					next_arready  = 1'b1;
				end
			end
			default: next_rd_state = dsg_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= dsg_pkg::RD_IDLE;
			arready  <= 1'b0;
			rvalid   <= 1'b0;
			rdata    <= 32'h0;
			rresp    <= dsg_pkg::RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			arready  <= next_arready;
			rvalid   <= next_rvalid;
			rdata    <= next_rdata;
			rresp    <= next_rresp;
		end
	end

	// one enable selector per unit
	genvar gi;
	generate
		for (gi = 0; gi < dsg_pkg::NUM_UNITS; gi++) begin : g_unit
			dsg_en_switch u_switch (
				.aclk     (aclk),
				.aresetn  (aresetn),
				.run_en   (run_units[gi]),
				.sleep_en (sleep_units[gi]),
				.deep_en  (deep_units[gi]),
				.auto_sel (auto_gate_select),
				.mode     (power_mode),
				.clk_en   (unit_clk_en[gi])
			);
		end
	endgenerate

	// judged against the enable the unit really has this cycle
	dsg_fault_check u_fault (
		.aclk    (aclk),
		.aresetn (aresetn),
		.access  (unit_access),
		.units   (unit_clk_en),
		.fault   (access_fault),
		.grant   (access_grant)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic deep_active;
	assign deep_active = auto_gate_select
		&& power_mode == dsg_pkg::PM_DEEP;

	sequence wr_commit_s;
		wst == dsg_pkg::WR_RESP && !bvalid && wr_hit_deep;
	endsequence

	sequence gated_access_s;
		unit_access.valid && unit_access.unit < dsg_pkg::NUM_UNITS_4
			&& !unit_clk_en[unit_access.unit];
	endsequence

	sequence rd_deep_s;
		arvalid && arready
			&& araddr[AW-1:2] == dsg_pkg::DEEP_GATE_OFS[AW-1:2];
	endsequence

	gate_on_a: assert property (deep_active |=>
		(unit_clk_en & $past(deep_units)) == $past(deep_units))
		else $error("enabled unit not clocked in deep sleep");

	gate_off_a: assert property (deep_active |=>
		(unit_clk_en & ~$past(deep_units)) == '0)
		else $error("disabled unit still clocked in deep sleep");

	fault_resp_a: assert property (gated_access_s |=>
		access_fault && !access_grant)
		else $error("access to gated unit not faulted");

	reset_zero_a: assert property (@(posedge aclk)
		disable iff (1'b0) !aresetn |=>
		deep_gate_reg == dsg_pkg::DEEP_GATE_RST && unit_clk_en == '0)
		else $error("gating state not zero after reset");

	run_src_a: assert property (power_mode == dsg_pkg::PM_RUN
		|=> unit_clk_en == $past(run_units))
		else $error("run mode not using run enables");

	sleep_src_a: assert property (auto_gate_select
		&& power_mode == dsg_pkg::PM_SLEEP
		|=> unit_clk_en == $past(sleep_units))
		else $error("auto sleep not using sleep enables");

	usb_bit_a: assert property (wr_commit_s and wstrb_h[2]
		|=> deep_gate_reg[16] == $past(wdata_h[16]))
		else $error("usb gate bit not written");

	dma_bit_a: assert property (wr_commit_s and wstrb_h[1]
		|=> deep_gate_reg[13] == $past(wdata_h[13]))
		else $error("dma gate bit not written");

	port_bits_a: assert property (wr_commit_s and wstrb_h[0]
		|=> deep_gate_reg[7:0] == $past(wdata_h[7:0]))
		else $error("port gate bits not written");

	reserved_zero_a: assert property (rd_deep_s |=>
		rvalid && rdata == $past(deep_gate_reg)
		&& (rdata & ~dsg_pkg::DEEP_WR_MASK) == 32'h0)
		else $error("reserved bits read nonzero");

	manual_src_a: assert property (!auto_gate_select
		|=> unit_clk_en == $past(run_units))
		else $error("manual mode not using run enables");
endmodule // dsg_top
`default_nettype wire

// ---- verif/dsg_access_model.sv ----
// partner: a bus initiator touching gated peripheral units
// assumes fault/grant pulse one cycle after the access edge
`timescale 1ns/100ps
`default_nettype none
module dsg_access_model (
	// clock
	input  wire logic                aclk,
	// access out, answer in
	output var dsg_pkg::dsg_access_t acc,
	input  wire logic                fault,
	input  wire logic                grant
);
	initial acc = '0;
	// gap + 1 idle cycles first, modelling a slow initiator
	task automatic probe(input logic [3:0] u, input int gap,
		output logic f, output logic g);
		repeat (gap + 1) @(posedge aclk);
		acc <= '{valid: 1'b1, unit: u};
		@(posedge aclk);
		// idle index flips so a stale unit is never trusted
		acc <= '{valid: 1'b0, unit: ~u};
		@(posedge aclk);
		f = fault;
		g = grant;
	endtask
endmodule // dsg_access_model
`default_nettype wire

// ---- verif/deep_sleep_clock_gating_tb_top.sv ----
// bench: AXI4-Lite master, mode sources and access partner
// assumes 20 MHz aclk and the designer's stated latencies
`timescale 1ns/100ps
`default_nettype none
module deep_sleep_clock_gating_tb_top;
	logic                aclk, aresetn, awvalid, awready, wvalid, wready;
	logic                bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0]         awaddr, araddr;
	logic [31:0]         wdata, rdata, run_gate_reg, sleep_gate_reg;
	logic [3:0]          wstrb;
	logic [1:0]          bresp, rresp;
	logic                auto_gate_select, access_fault, access_grant;
	dsg_pkg::dsg_pmode_t power_mode;
	dsg_pkg::dsg_access_t unit_access;
	dsg_pkg::dsg_units_t unit_clk_en;
	logic [31:0]         seed, dreg, d, q;
	logic [9:0]          ex;
	logic [1:0]          r;
	logic [3:0]          s;
	logic                f, g;
	int                  fail_count, samples_checked;

	dsg_top u_dsg_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.power_mode(power_mode), .auto_gate_select(auto_gate_select),
		.run_gate_reg(run_gate_reg), .sleep_gate_reg(sleep_gate_reg),
		.unit_access(unit_access), .access_fault(access_fault),
		.access_grant(access_grant), .unit_clk_en(unit_clk_en));
	dsg_access_model u_dsg_access_model (.aclk(aclk), .acc(unit_access),
		.fault(access_fault), .grant(access_grant));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [9:0] units_of(input logic [31:0] w);
		return {w[16], w[13], w[7:0]};
	endfunction
	// mode 3 counts as run; auto clear always takes run enables
	function automatic logic [9:0] exp_en(input logic [1:0] m, input logic a,
		input logic [31:0] rw, sw, dw);
		if (a && m == 2'h1) return units_of(sw);
		if (a && m == 2'h2) return units_of(dw);
		return units_of(rw);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, w,
		input logic [3:0] st);
		for (int k = 0; k < 4; k++) if (st[k]) o[8*k+:8] = w[8*k+:8];
		return o & 32'h0001_20ff;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] w,
		input logic [3:0] st, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= a;
		wdata <= w;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] w,
		output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		w = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checked %0d, mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		end_of_test();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{run_gate_reg, sleep_gate_reg, auto_gate_select} = '0;
		power_mode = dsg_pkg::PM_RUN;
		seed = 32'hdafb806b;
		dreg = '0;
		fail_count = 0;
		samples_checked = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(12'h128, q, r);
		chk(q, 32'h0);
		chk(32'(unit_clk_en), 32'h0);
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : rnd();
			s = (i < 3) ? 4'hf : 4'(rnd());
			axw(12'h128, d, s, r);
			chk(32'(r), 32'h0);
			dreg = merge(dreg, d, s);
			axr(12'h128, q, r);
			chk(q, dreg);
			power_mode <= dsg_pkg::dsg_pmode_t'(i[1:0]);
			auto_gate_select <= i[2];
			run_gate_reg <= rnd();
			sleep_gate_reg <= rnd();
			repeat (2) @(posedge aclk);
			ex = exp_en(power_mode, auto_gate_select, run_gate_reg,
				sleep_gate_reg, dreg);
			chk(32'(unit_clk_en), 32'(ex));
			d = rnd();
			u_dsg_access_model.probe(d[3:0], int'(d[5:4]), f, g);
			ex = (d[3:0] < 4'ha) ? (ex >> d[3:0]) & 10'h1 : 10'h0;
			chk(32'({f, g}), 32'({~ex[0], ex[0]}));
		end
		$display("random test done");
		axr(12'h130, q, r);
		chk(32'(r), 32'h3);
		chk(q, 32'h0);
		axw(12'h000, 32'hffff_ffff, 4'hf, r);
		chk(32'(r), 32'h3);
		axw(12'h12c, 32'hffff_ffff, 4'hf, r);
		chk(32'(r), 32'h0);
		axr(12'h128, q, r);
		chk(q, dreg);
		power_mode <= dsg_pkg::PM_DEEP;
		auto_gate_select <= 1'b1;
		// read-modify-write keeps reserved bits, enables port a first
		axw(12'h128, q | 32'h1, 4'hf, r);
		u_dsg_access_model.probe(4'h0, 0, f, g);
		chk(32'({f, g}), 32'h1);
		axr(12'h12c, q, r);
		chk(q, (dreg | 32'h1));
		$display("map test done");
		// mid-run reset with units enabled must drop every enable again
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(12'h128, q, r);
		chk(q, 32'h0);
		chk(32'(unit_clk_en), 32'h0);
		u_dsg_access_model.probe(4'h0, 0, f, g);
		chk(32'({f, g}), 32'h2);
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule // deep_sleep_clock_gating_tb_top
`default_nettype wire
